// *** logic/ssl_device.sv ***
// device end: serial input register, three latches, power-down and counter reset
`timescale 1ns/1ps
`default_nettype none
module ssl_device
	import ssl_pkg::*;
#(
	parameter int CNT_W = 14 // width of model divider counters
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// link
	ssl_if.device link,
	// user side: latched words and derived status
	output logic [23:0] ref_latch,
	output logic [23:0] ab_latch,
	output logic [23:0] func_latch,
	output logic powered_down,
	output logic pump_tristate,
	output logic counters_held,
	output logic [CNT_W-1:0] ref_count,
	output logic [CNT_W-1:0] ab_count
);
	// elaboration check: counters and count ports are sized for 2 to 14 bits
	if (CNT_W < 2 || CNT_W > 14) begin : g_bad_cnt_w
		$error("ssl_device: CNT_W must lie between 2 and 14");
	end
	// select field compare, shared by the three latch enables
	function automatic logic sel_hit(input logic [1:0] sel_in, input logic [1:0] code);
		return sel_in == code;
	endfunction : sel_hit
	// synchronised link levels
	logic sclk_s; // serial clock, four flops deep
	logic sdata_s; // serial data, same depth as the clock
	logic strobe_low_s; // inverted load strobe, idles low like the flops after reset
	// edge history
	logic sclk_d_reg; // last sampled clock level
	logic strobe_d_reg; // last sampled strobe level
	// serial input register and destination latches
	logic [23:0] shift_reg; // serial input register
	logic [23:0] ref_reg; // reference divider word
	logic [23:0] ab_reg; // a and b divider word
	logic [23:0] func_reg; // function word: resets, power, pump, monitor
	// model divider counters
	logic [CNT_W-1:0] rcnt_reg; // reference side
	logic [CNT_W-1:0] ncnt_reg; // a and b side
	// clock and data share one synchroniser depth, so their pin timing is kept
	ssl_sync u_sync_clk (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.din(link.sclk),
		.dout(sclk_s)
	);
	// data moves only while the clock is low, so it is settled at every rise
	ssl_sync u_sync_dat (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.din(link.sdata),
		.dout(sdata_s)
	);
	// the strobe idles high; syncing its inverse keeps the reset value at idle,
	// so no false strobe edge and no stray latch load follow reset
	ssl_sync u_sync_stb (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.din(~link.load_strobe),
		.dout(strobe_low_s)
	);
	// strobe level back in its own sense
	wire strobe_s = ~strobe_low_s;
	// edge detection on the cleaned levels
	wire sclk_rise = sclk_s & ~sclk_d_reg; // one cycle per serial clock rise
	wire strobe_rise = strobe_s & ~strobe_d_reg; // one cycle per strobe rise
	// select field always sits in the two low bits of the word
	wire [1:0] sel = shift_reg[SSL_SEL_POS +: 2];
	wire load_ref = strobe_rise && sel_hit(sel, SSL_SEL_REF); // reference latch
	wire load_ab = strobe_rise && sel_hit(sel, SSL_SEL_AB); // a and b latch
	wire load_func = strobe_rise && sel_hit(sel, SSL_SEL_FUNC); // function latch
	// the fourth select code matches none of these and is dropped on purpose
	// async power-down: pin goes straight in, no clock needed
	wire pd_async = ~link.pwr_en;
	// software power-down bit of the function word
	wire soft_pd = func_reg[SSL_PWR_DN_POS];
	// counter reset bit of the function word
	wire cnt_rst = func_reg[SSL_CNT_RST_POS];
	// counter reset holds counters without powering down
	wire hold = pd_async | soft_pd | cnt_rst;
	// monitor select field of the function word; zero turns the monitor off
	wire [2:0] mon_sel = func_reg[SSL_MUX_POS +: 3];
	// pump tri-state control bit of the function word
	wire tri_bit = func_reg[SSL_TRI_POS];
	// edge history registers
	// reset to the idle levels of both lines, so the first edge after reset is real
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			// clock idles low
			sclk_d_reg <= 1'b0;
			// strobe idles high
			strobe_d_reg <= 1'b1;
		end else begin
			// follow the cleaned levels one cycle behind
			sclk_d_reg <= sclk_s;
			strobe_d_reg <= strobe_s;
		end
	end
	// input register is never gated by power state
	// loads accepted during power-down
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			// system reset only; power-down leaves it alone
			shift_reg <= SSL_LATCH_RST;
		end else if (sclk_rise) begin
			// oldest bits fall off the top
			shift_reg <= {shift_reg[22:0], sdata_s};
		end
	end
	// no clear on power-down, only on system reset
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			// all three latches start from the reset word
			ref_reg <= SSL_LATCH_RST;
			ab_reg <= SSL_LATCH_RST;
			func_reg <= SSL_LATCH_RST;
		end else begin
			// reference word
			if (load_ref) begin
				ref_reg <= shift_reg;
			end
			// a and b word
			if (load_ab) begin
				ab_reg <= shift_reg;
			end
			// function word; its controls act from the next cycle
			if (load_func) begin
				func_reg <= shift_reg;
			end
		end
	end
	// model divider counters; the power pin also clears them asynchronously
	// a limitation: they only stand in for the real dividers, counting system clocks
	always_ff @(posedge clk_sys or negedge rst_b or posedge pd_async) begin
		if (!rst_b) begin
			// system reset
			rcnt_reg <= '0;
			ncnt_reg <= '0;
		end else if (pd_async) begin
			// forced to load state at once
			rcnt_reg <= '0;
			ncnt_reg <= '0;
		end else if (hold) begin
			rcnt_reg <= '0;
			ncnt_reg <= '0;
		end else begin
			// both leave the load point on the same edge
			rcnt_reg <= rcnt_reg + 1'b1;
			ncnt_reg <= ncnt_reg + 1'b1;
		end
	end
	// latched words straight out
	assign ref_latch = ref_reg;
	assign ab_latch = ab_reg;
	assign func_latch = func_reg;
	// power-down from the pin or the software bit
	assign powered_down = pd_async | soft_pd;
	// pump tri-state from hold or its own control bit
	assign pump_tristate = hold | tri_bit;
	// counters held whenever a power-down or counter reset stands
	assign counters_held = hold;
	// counter values
	assign ref_count = rcnt_reg;
	assign ab_count = ncnt_reg;
	// monitor: counters running and a nonzero monitor select
	// the port is write only, so this pin is the host's only view of the device
	assign link.monitor_output = (mon_sel != 3'h0) & ~hold;
endmodule : ssl_device
`default_nettype wire

// *** logic/ssl_pkg.sv ***
// shared constants for the synthesizer serial load port and its host
package ssl_pkg;
	// serial word layout
	localparam int SSL_WORD_BITS = 24;
	localparam int SSL_SEL_POS = 0;
	localparam int SSL_CNT_RST_POS = 2;
	localparam int SSL_PWR_DN_POS = 3;
	localparam int SSL_TRI_POS = 8;
	localparam int SSL_MUX_POS = 4;
	// latch select codes
	localparam logic [1:0] SSL_SEL_REF = 2'h0;
	localparam logic [1:0] SSL_SEL_AB = 2'h1;
	localparam logic [1:0] SSL_SEL_FUNC = 2'h2;
	// values after reset
	localparam logic [23:0] SSL_LATCH_RST = 24'h00_0000;
	// serial clock timing: host half period at 100 MHz system clock
	localparam int SSL_SCLK_MAX_MHZ = 20;
	localparam int SSL_SYS_MHZ = 100;
	// least half period, rounded up, for sclk at or under 20 MHz
	localparam int SSL_HALF_CYC = (SSL_SYS_MHZ + 2 * SSL_SCLK_MAX_MHZ - 1) / (2 * SSL_SCLK_MAX_MHZ);
	// host register offsets
	localparam logic [3:0] SSL_OFS_DATA = 4'h0;
	localparam logic [3:0] SSL_OFS_CTRL = 4'h4;
	localparam logic [3:0] SSL_OFS_STAT = 4'h8;
	// host sequencer state
	typedef enum logic [2:0] {SSL_IDLE, SSL_LOW, SSL_HIGH, SSL_STROBE, SSL_GAP} ssl_state_e;
endpackage : ssl_pkg

// *** logic/ssl_if.sv ***
// three-wire load link plus power enable and monitor between host and device
`timescale 1ns/1ps
`default_nettype none
interface ssl_if;
	logic sclk;          // serial clock
	logic sdata;         // serial data
	logic load_strobe;   // load strobe, rising edge latches
	logic pwr_en;        // power enable, low powers down
	logic monitor_output; // monitor output from device
	modport device (input sclk, input sdata, input load_strobe, input pwr_en, output monitor_output);
	modport host (output sclk, output sdata, output load_strobe, output pwr_en, input monitor_output);
endinterface : ssl_if
`default_nettype wire

// *** logic/ssl_sync.sv ***
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
`default_nettype none
module ssl_sync (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// async input and clean level
	input wire logic din,
	output logic dout
);
	logic s1_reg; // metastable stage, read only by s2
	logic s2_reg;
	logic s3_reg;
	logic out_reg;
	// output changes only once stage two and three agree
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			out_reg <= 1'b0;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				out_reg <= s3_reg;
			end
		end
	end
	assign dout = out_reg;
endmodule : ssl_sync
`default_nettype wire

// *** logic/ssl_host.sv ***
// host end: register port, serial shifter and strobe generation
`timescale 1ns/1ps
`default_nettype none
module ssl_host
	import ssl_pkg::*;
(
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// register port
	input wire logic [3:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata,
	// link
	ssl_if.host link
);
	logic [31:0] rdata_reg;
	logic [23:0] word_reg; // word being sent
	logic pwr_en_reg; // power enable level
	logic [4:0] bit_reg; // bits left
	logic [2:0] div_reg; // half period counter
	logic sclk_reg;
	logic sdata_reg;
	logic strobe_reg;
	logic mon_s;
	ssl_state_e state_reg;
	ssl_sync u_sync_mon (.clk_sys(clk_sys), .rst_b(rst_b), .din(link.monitor_output), .dout(mon_s));
	wire busy = (state_reg != SSL_IDLE);
	wire start = wr && (addr == SSL_OFS_DATA) && !busy;
	wire half_done = (div_reg == 3'(SSL_HALF_CYC - 1));
	// read mux: ctrl, status, else zero
	wire [31:0] rd_mux = (addr == SSL_OFS_CTRL) ? {31'h0, pwr_en_reg} :
		(addr == SSL_OFS_STAT) ? {30'h0, mon_s, busy} : 32'h0000_0000;
	// read data one cycle after strobe
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) rdata_reg <= 32'h0000_0000;
		else rdata_reg <= rd ? rd_mux : 32'h0000_0000;
	end
	// power enable; software drives it low before loading
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) pwr_en_reg <= 1'b0;
		else if (wr && addr == SSL_OFS_CTRL) pwr_en_reg <= wdata[0];
	end
	// serial sequencer
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= SSL_IDLE;
			word_reg <= 24'h00_0000;
			bit_reg <= 5'h00;
			div_reg <= 3'h0;
			sclk_reg <= 1'b0;
			sdata_reg <= 1'b0;
			strobe_reg <= 1'b1;
		end else begin
			div_reg <= half_done ? 3'h0 : div_reg + 3'h1;
			case (state_reg)
				SSL_IDLE: begin
					if (start) begin
						strobe_reg <= 1'b0;
						word_reg <= {wdata[22:0], 1'b0};
						sdata_reg <= wdata[23];
						bit_reg <= 5'h17;
						div_reg <= 3'h0;
						state_reg <= SSL_LOW;
					end
				end
				SSL_LOW: begin
					// data set while clock low, half period bound
					if (half_done) begin
						sclk_reg <= 1'b1;
						state_reg <= SSL_HIGH;
					end
				end
				SSL_HIGH: begin
					if (half_done) begin
						sclk_reg <= 1'b0;
						if (bit_reg == 5'h00) begin
							state_reg <= SSL_STROBE;
						end else begin
							sdata_reg <= word_reg[23];
							word_reg <= {word_reg[22:0], 1'b0};
							bit_reg <= bit_reg - 5'h01;
							state_reg <= SSL_LOW;
						end
					end
				end
				SSL_STROBE: begin
					// strobe high after all 24 bits
					if (half_done) begin
						strobe_reg <= 1'b1;
						state_reg <= SSL_GAP;
					end
				end
				SSL_GAP: begin
					if (half_done) state_reg <= SSL_IDLE;
				end
				default: state_reg <= SSL_IDLE;
			endcase
		end
	end
	assign rdata = rdata_reg;
	assign link.sclk = sclk_reg;
	assign link.sdata = sdata_reg;
	assign link.load_strobe = strobe_reg;
	assign link.pwr_en = pwr_en_reg;
endmodule : ssl_host
`default_nettype wire

// *** verif/ssl_link_asserts.sv ***
// wire checks on the serial load link between host and device
`timescale 1ns/1ps
`default_nettype none
module ssl_link_asserts (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// link wires
	input wire logic sclk,
	input wire logic sdata,
	input wire logic load_strobe,
	input wire logic pwr_en,
	input wire logic monitor_output
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	// rising sclk edges seen in the current frame
	logic [5:0] rise_reg;
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) rise_reg <= 6'h00;
		else if (load_strobe) rise_reg <= 6'h00;
		else if ($rose(sclk)) rise_reg <= rise_reg + 6'h01;
	end
	property p_frame_bits; $rose(load_strobe) |-> rise_reg == 6'h18; endproperty
	a_frame_bits: assert property (p_frame_bits) else $error("frame not 24 bits");
	property p_sclk_high; $rose(sclk) |=> sclk [*2]; endproperty
	a_sclk_high: assert property (p_sclk_high) else $error("sclk high too short");
	property p_sclk_low; $fell(sclk) |=> !sclk [*2]; endproperty
	a_sclk_low: assert property (p_sclk_low) else $error("sclk low too short");
	property p_data_hold; $rose(sclk) |-> $stable(sdata); endproperty
	a_data_hold: assert property (p_data_hold) else $error("data moved at sclk rise");
	property p_clk_framed; load_strobe |-> !sclk; endproperty
	a_clk_framed: assert property (p_clk_framed) else $error("sclk high outside frame");
	property p_strobe_low; $fell(load_strobe) |-> !load_strobe [*8]; endproperty
	a_strobe_low: assert property (p_strobe_low) else $error("strobe low too short");
	property p_frame_len; $fell(load_strobe) |-> ##[100:200] $rose(load_strobe); endproperty
	a_frame_len: assert property (p_frame_len) else $error("frame length off");
	property p_mon_off; !pwr_en |-> !monitor_output; endproperty
	a_mon_off: assert property (p_mon_off) else $error("monitor active in power-down");
endmodule : ssl_link_asserts
`default_nettype wire

// *** verif/tb.sv ***
// bench: host and device joined, both start-up sequences and random words
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ssl_pkg::*;
	// clock, reset, register port
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] rdata;
	// device user side
	wire logic [2:0][23:0] lat;
	wire logic pd, tri_o, held;
	wire logic [13:0] rc, ac;
	int fail_count = 0;
	int n_tests = 0;
	logic [31:0] seed = 32'h5ea1;
	logic [23:0] exp_l [3];
	ssl_if link();
	always #5 clk_sys = ~clk_sys;
	ssl_host i_ssl_host (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .link(link));
	ssl_device i_ssl_device (.clk_sys(clk_sys), .rst_b(rst_b), .link(link), .ref_latch(lat[0]),
		.ab_latch(lat[1]), .func_latch(lat[2]), .powered_down(pd), .pump_tristate(tri_o),
		.counters_held(held), .ref_count(rc), .ab_count(ac));
	ssl_link_asserts i_ssl_link_asserts (.clk_sys(clk_sys), .rst_b(rst_b), .sclk(link.sclk),
		.sdata(link.sdata), .load_strobe(link.load_strobe), .pwr_en(link.pwr_en),
		.monitor_output(link.monitor_output));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk
	// one-bit status flags
	task automatic chk_bit(input logic g, input logic e);
		chk(32'(g), 32'(e));
	endtask : chk_bit
	task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask : wr_reg
	// read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : rd_reg
	task automatic lats();
		for (int k = 0; k < 3; k++) chk(32'(lat[k]), 32'(exp_l[k]));
	endtask : lats
	// status flags from pin level and function word
	task automatic flags(input logic pe);
		chk_bit(pd, !pe | exp_l[2][SSL_PWR_DN_POS]);
		chk_bit(held, !pe | exp_l[2][SSL_PWR_DN_POS] | exp_l[2][SSL_CNT_RST_POS]);
		chk_bit(tri_o, !pe | exp_l[2][SSL_PWR_DN_POS] | exp_l[2][SSL_CNT_RST_POS] | exp_l[2][SSL_TRI_POS]);
	endtask : flags
	// one random word; busy polled with a bound, then latch settle
	task automatic go(input logic [1:0] sel, input logic [1:0] fb);
		logic [23:0] w;
		logic [31:0] s;
		seed = lfsr(seed);
		w = {seed[21:0], sel};
		if (sel == SSL_SEL_FUNC) begin
			// fb: soft power-down over counter reset
			w[SSL_PWR_DN_POS] = fb[1];
			w[SSL_CNT_RST_POS] = fb[0];
		end
		wr_reg(SSL_OFS_DATA, {8'h00, w});
		for (int i = 0; i < 200; i++) begin
			rd_reg(SSL_OFS_STAT, s);
			if (s[0] === 1'b0) break;
		end
		chk_bit(s[0], 1'b0);
		repeat (10) @(posedge clk_sys);
		if (sel != 2'b11) exp_l[sel] = w;
		lats();
	endtask : go
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test
	initial begin
		#300000;
		fail_count++;
		finish_test();
	end
	initial begin
		logic [31:0] r;
		exp_l = '{default: SSL_LATCH_RST};
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		// reset state, unmapped read
		rd_reg(SSL_OFS_CTRL, r);
		chk(r, 32'h0000_0000);
		rd_reg(4'hc, r);
		chk(r, 32'h0000_0000);
		lats();
		flags(1'b0);
		// enable-pin start: loads while powered down
		go(SSL_SEL_FUNC, 2'h0);
		go(SSL_SEL_REF, 2'h0);
		go(SSL_SEL_AB, 2'h0);
		flags(1'b0);
		wr_reg(SSL_OFS_CTRL, 32'h0000_0001);
		repeat (20) @(posedge clk_sys);
		flags(1'b1);
		chk(32'(rc), 32'(ac));
		chk_bit(rc != 14'h0000, 1'b1);
		// pin low powers down with no clock edge
		wr_reg(SSL_OFS_CTRL, 32'h0000_0000);
		@(negedge link.pwr_en);
		#1 chk_bit(pd, 1'b1);
		wr_reg(SSL_OFS_CTRL, 32'h0000_0001);
		repeat (20) @(posedge clk_sys);
		flags(1'b1);
		lats();
		// soft power-down bit, then a load while it stands
		go(SSL_SEL_FUNC, 2'h2);
		flags(1'b1);
		chk_bit(rc == 14'h0000, 1'b1);
		go(SSL_SEL_AB, 2'h0);
		// counter-reset start, unused select in between
		go(SSL_SEL_FUNC, 2'h1);
		flags(1'b1);
		chk(32'(rc), 32'h0000_0000);
		go(SSL_SEL_REF, 2'h0);
		go(2'b11, 2'h0);
		go(SSL_SEL_AB, 2'h0);
		go(SSL_SEL_FUNC, 2'h0);
		repeat (20) @(posedge clk_sys);
		flags(1'b1);
		chk(32'(rc), 32'(ac));
		rd_reg(SSL_OFS_STAT, r);
		chk_bit(r[1], exp_l[2][SSL_MUX_POS +: 3] != 3'h0);
		// random selects back to back
		for (int i = 0; i < 6; i++) go(seed[1:0], 2'h0);
		finish_test();
	end
endmodule : tb
`default_nettype wire
